/* bench/dfs_fabric_model.sv */
// user fabric logic that drives the flop element pins
`timescale 1ns/1ps
`default_nettype none

module dfs_fabric_model (
    input wire logic pclk,
    output logic flop_clk,
    output logic flop_d,
    output logic flop_en,
    output logic clear_low,
    output logic set_low
);
    initial begin
        flop_clk = 1'b0;
        flop_d = 1'b0;
        flop_en = 1'b0;
        clear_low = 1'b1;
        set_low = 1'b1;
    end

    // pins stay put 8 pclk so the 2-flop sync and edge detect settle
    task automatic put(input logic d, input logic en, input logic c, input logic s);
        @(posedge pclk);
        flop_d <= d;
        flop_en <= en;
        clear_low <= c;
        set_low <= s;
        repeat (8) @(posedge pclk);
    endtask : put

    // phases of 8 pclk, well above the shortest phase the sync can see
    task automatic tick(input logic pos);
        @(posedge pclk);
        flop_clk <= !pos;
        repeat (8) @(posedge pclk);
        flop_clk <= pos;
        repeat (8) @(posedge pclk);
    endtask : tick
endmodule : dfs_fabric_model

`default_nettype wire

/* bench/dfs_top_tb.sv */
// self-checking bench for the flop family top
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.svh"

module dfs_top_tb
    import dfs_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [`DFS_ADDR_W-1:0] paddr;
    logic [`DFS_DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic flop_clk, flop_d, flop_en, clear_low, set_low, flop_q;
    logic er, q, d, en, r, frc;
    int bad_count = 0;
    int n_compared = 0;

    dfs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .flop_clk(flop_clk),
        .flop_d(flop_d), .flop_en(flop_en), .clear_low(clear_low),
        .set_low(set_low), .flop_q(flop_q));

    dfs_fabric_model drv (.pclk(pclk), .flop_clk(flop_clk), .flop_d(flop_d),
        .flop_en(flop_en), .clear_low(clear_low), .set_low(set_low));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = !pclk;
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // master waits for pready as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check("apb_wait", 32'(n), 32'h2);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        stop_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        void'($urandom(32'h8AE5));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("q_reset", 32'(flop_q), 32'h1);
        apb(1'b0, `DFS_CTRL_OFF, 32'h0);
        check("ctrl_reset", rd, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped_err", 32'(er), 32'h1);
        check("unmapped_data", rd, 32'h0);
        for (int c = 0; c < 2; c++) begin
            for (int v = 0; v < 4; v++) begin
                frc = (v == 0 || v == 2);
                // unclocked pass always loads the value opposite to the force
                r = (c == 0) ? !frc : 1'($urandom);
                apb(1'b1, `DFS_CTRL_OFF, 32'h108 | (32'(r) << 4) | (32'(c) << 2) | 32'(v));
                repeat (3) @(posedge pclk);
                q = r;
                check("load", 32'(flop_q), 32'(q));
                for (int i = 0; i < 6; i++) begin
                    d = 1'($urandom);
                    en = 1'($urandom);
                    drv.put(d, en, 1'b1, 1'b1);
                    drv.tick(v == 3);
                    q = (v == 0 && !en) ? q : d;
                    check("data", 32'(flop_q), 32'(q));
                end
                // force low with no clock edge: only the unclocked mode reacts
                drv.put(!frc, 1'b0, frc, !frc);
                q = (c == 1) ? q : frc;
                check("force_noedge", 32'(flop_q), 32'(q));
                drv.tick(v == 3);
                q = frc;
                check("force_edge", 32'(flop_q), 32'(q));
                drv.put(!frc, 1'b1, 1'b1, 1'b1);
                check("hold", 32'(flop_q), 32'(q));
                apb(1'b0, `DFS_STAT_OFF, 32'h0);
                check("status_q", 32'(rd[0]), 32'(q));
                check("status_pins", 32'(rd[5:1]), 32'({3'b111, 1'(v == 3), !frc}));
            end
        end
        // seven active edges per variant pass, eight passes
        apb(1'b0, `DFS_EDGE_OFF, 32'h0);
        check("edges", rd, 32'h38);
        // a second reset must drop the clocked mode written above
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("q_rereset", 32'(flop_q), 32'h1);
        apb(1'b0, `DFS_CTRL_OFF, 32'h0);
        check("ctrl_rereset", rd, 32'h0);
        stop_test();
    end
endmodule : dfs_top_tb

`default_nettype wire

/* hw/dfs_flop_core.sv */
// the one-bit storage element with force, enable and power-up load
`timescale 1ns/1ps
`default_nettype none

module dfs_flop_core
    import dfs_pkg::*;
#(
    parameter logic RESET_Q = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire dfs_cfg_t cfg,
    input wire dfs_pins_t pins,
    input wire logic active_edge,
    input wire logic load,
    output logic q
);

    typedef struct packed {
        logic q;
    } dfs_core_st_t;

    dfs_core_st_t st;
    dfs_core_st_t next_st;
    logic frc;
    logic fv;
    logic iv;

    always_comb begin
        next_st = st;
        frc = dfs_force_act(cfg.variant, pins);
        fv = dfs_forced_val(cfg.variant);
        iv = cfg.init_ovr ? cfg.init_val : fv;
        if (load) begin
            // any init value, opposite to force too, is just a load
            next_st.q = iv;
        end else if (frc && (!cfg.clocked || active_edge)) begin
            // force beats clock, data and enable
            next_st.q = fv;
        end else if (active_edge && !frc && (pins.en || !dfs_has_enable(cfg.variant))) begin
            next_st.q = pins.d;
        end
        // otherwise hold
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{q: RESET_Q};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule : dfs_flop_core

`default_nettype wire

/* hw/dfs_top.sv */
// flop family top: pin synchronisers, edge detect, apb registers, checks
`timescale 1ns/1ps
`default_nettype none

module dfs_top
    import dfs_pkg::*;
#(
    parameter dfs_variant_e VARIANT = NEG_EN_SET,
    parameter logic CLOCKED = 1'b0,
    parameter logic INIT_OVR = 1'b0,
    parameter logic INIT_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DFS_ADDR_W-1:0] paddr,
    input wire logic [`DFS_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [`DFS_DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic flop_clk,
    input wire logic flop_d,
    input wire logic flop_en,
    input wire logic clear_low,
    input wire logic set_low,
    output logic flop_q
);

    localparam dfs_cfg_t RST_CFG = '{
        variant: VARIANT,
        clocked: CLOCKED,
        init_ovr: INIT_OVR,
        init_val: INIT_VAL
    };

    // force inputs idle high so reset never looks like a force
    localparam dfs_pins_t PINS_IDLE = '{
        clk: 1'b0,
        d: 1'b0,
        en: 1'b0,
        clear_low: 1'b1,
        set_low: 1'b1
    };

    localparam logic RESET_Q = INIT_OVR ? INIT_VAL : dfs_forced_val(VARIANT);

    typedef struct packed {
        dfs_cfg_t cfg;
        dfs_pins_t s1;
        dfs_pins_t s2;
        logic clk_prev;
        logic load;
        logic rdy;
        logic err;
        logic [`DFS_DATA_W-1:0] rdata;
        logic [`DFS_EDGE_W-1:0] edges;
        logic seen;
    } dfs_top_st_t;

    localparam dfs_top_st_t RST_ST = '{
        cfg: RST_CFG,
        s1: PINS_IDLE,
        s2: PINS_IDLE,
        clk_prev: 1'b0,
        load: 1'b0,
        rdy: 1'b0,
        err: 1'b0,
        rdata: '0,
        edges: '0,
        seen: 1'b0
    };

    dfs_top_st_t st;
    dfs_top_st_t next_st;
    dfs_pins_t pins_raw;
    logic rise;
    logic fall;
    logic act;
    logic frc;
    logic fv;
    logic iv;
    logic acc;

    function automatic dfs_sel_e dfs_decode(input logic [`DFS_ADDR_W-1:0] a);
        case (a)
            `DFS_CTRL_OFF: return SEL_CTRL;
            `DFS_STAT_OFF: return SEL_STAT;
            `DFS_EDGE_OFF: return SEL_EDGE;
            default: return SEL_NONE;
        endcase
    endfunction : dfs_decode

    function automatic logic [`DFS_DATA_W-1:0] dfs_read(
        input dfs_sel_e sel,
        input dfs_top_st_t s,
        input logic q
    );
        logic [`DFS_DATA_W-1:0] r;
        r = '0;
        case (sel)
            SEL_CTRL: begin
                r[`DFS_CTRL_VAR_LSB +: 2] = s.cfg.variant;
                r[`DFS_CTRL_CLOCKED] = s.cfg.clocked;
                r[`DFS_CTRL_INIT_OVR] = s.cfg.init_ovr;
                r[`DFS_CTRL_INIT_VAL] = s.cfg.init_val;
            end
            SEL_STAT: begin
                r[`DFS_STAT_Q] = q;
                r[`DFS_STAT_D] = s.s2.d;
                r[`DFS_STAT_CLK] = s.s2.clk;
                r[`DFS_STAT_EN] = s.s2.en;
                r[`DFS_STAT_CLR] = s.s2.clear_low;
                r[`DFS_STAT_SET] = s.s2.set_low;
            end
            SEL_EDGE: begin
                r[`DFS_EDGE_W-1:0] = s.edges;
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction : dfs_read

    assign pins_raw = '{
        clk: flop_clk,
        d: flop_d,
        en: flop_en,
        clear_low: clear_low,
        set_low: set_low
    };

    // edges are seen on the synchronised copy only; the user clock must
    // stay well below pclk/4 so that no edge is lost
    assign rise = st.s2.clk && !st.clk_prev;
    assign fall = !st.s2.clk && st.clk_prev;
    assign act = (st.cfg.variant == POS_CLEAR) ? rise : fall;
    assign frc = dfs_force_act(st.cfg.variant, st.s2);
    assign fv = dfs_forced_val(st.cfg.variant);
    assign iv = st.cfg.init_ovr ? st.cfg.init_val : fv;
    assign acc = psel && penable;

    always_comb begin
        next_st = st;
        next_st.s1 = pins_raw;
        next_st.s2 = st.s1;
        next_st.clk_prev = st.s2.clk;
        next_st.load = 1'b0;
        next_st.rdy = 1'b0;
        next_st.err = 1'b0;
        next_st.seen = 1'b1;
        if (act) begin
            next_st.edges = st.edges + 1'b1;
        end
        // one wait state: read data is caught at the same edge that raises pready
        if (acc && !st.rdy) begin
            next_st.rdy = 1'b1;
            next_st.err = dfs_decode(paddr) == SEL_NONE;
            next_st.rdata = pwrite ? '0 : dfs_read(dfs_decode(paddr), st, flop_q);
        end
        // writes land only at the edge that samples pready high
        if (acc && st.rdy && pwrite && dfs_decode(paddr) == SEL_CTRL) begin
            if (pstrb[0]) begin
                next_st.cfg.variant = dfs_variant_e'(pwdata[`DFS_CTRL_VAR_LSB +: 2]);
                next_st.cfg.clocked = pwdata[`DFS_CTRL_CLOCKED];
                next_st.cfg.init_ovr = pwdata[`DFS_CTRL_INIT_OVR];
                next_st.cfg.init_val = pwdata[`DFS_CTRL_INIT_VAL];
            end
            if (pstrb[1]) begin
                next_st.load = pwdata[`DFS_CTRL_LOAD];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    dfs_flop_core #(
        .RESET_Q(RESET_Q)
    ) u_core (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(st.cfg),
        .pins(st.s2),
        .active_edge(act),
        .load(st.load),
        .q(flop_q)
    );

    assign pready = st.rdy;
    assign prdata = st.rdata;
    assign pslverr = st.err;

    default clocking dfs_cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    a_fall_capture: assert property (
        (st.cfg.variant != POS_CLEAR) && act && !frc && !st.load
        && (st.s2.en || !dfs_has_enable(st.cfg.variant))
        |=> flop_q == $past(st.s2.d)
    ) else $error("falling edge did not capture data");

    a_rise_capture: assert property (
        (st.cfg.variant == POS_CLEAR) && act && !frc && !st.load
        |=> flop_q == $past(st.s2.d)
    ) else $error("rising edge did not capture data");

    a_enable_hold: assert property (
        (st.cfg.variant == NEG_EN_SET) && !st.s2.en && !frc && !st.load
        |=> $stable(flop_q)
    ) else $error("output moved while enable low");

    a_clear_force: assert property (
        !fv && !st.cfg.clocked && frc && !st.load
        |=> !flop_q
    ) else $error("unclocked clear did not force zero");

    a_set_force: assert property (
        fv && !st.cfg.clocked && frc && !st.load
        |=> flop_q
    ) else $error("unclocked set did not force one");

    a_clocked_wait: assert property (
        st.cfg.clocked && frc && !act && !st.load
        |=> $stable(flop_q)
    ) else $error("clocked force acted without an edge");

    a_clocked_edge: assert property (
        st.cfg.clocked && frc && act && !st.load
        |=> flop_q == $past(fv)
    ) else $error("clocked force missed its edge");

    sequence dfs_force_run;
        (!st.cfg.clocked && frc && !st.load && !act) [*2];
    endsequence

    a_force_steady: assert property (
        dfs_force_run |=> flop_q == $past(fv, 2)
    ) else $error("unclocked force did not hold output");

    a_default_mode: assert property (
        !st.seen && !CLOCKED |-> !st.cfg.clocked
    ) else $error("force timing not unclocked after reset");

    a_power_up: assert property (
        !st.seen |-> flop_q == RESET_Q
    ) else $error("output not at power-up value");

    a_opposite_init: assert property (
        st.load && !st.cfg.clocked && (iv != fv)
        |=> flop_q == $past(iv)
    ) else $error("opposite init value not provided");

    a_hold_quiet: assert property (
        !frc && !act && !st.load |=> $stable(flop_q)
    ) else $error("output changed with no edge or force");

    a_set_over_en: assert property (
        (st.cfg.variant == NEG_EN_SET) && st.cfg.clocked && frc && act
        && !st.s2.en && !st.load
        |=> flop_q
    ) else $error("clocked set lost to low enable");

    a_apb_answer: assert property (
        acc && !pready |=> pready
    ) else $error("apb access not answered in one wait state");

    // bus handshake shape: one-cycle answer, error only on unmapped words
    a_ready_pulse: assert property (
        pready |=> !pready
    ) else $error("pready stood longer than one cycle");

    a_ready_idle: assert property (
        !acc |=> !pready
    ) else $error("pready raised without an access");

    a_err_unmapped: assert property (
        pready |-> pslverr == (dfs_decode(paddr) == SEL_NONE)
    ) else $error("pslverr does not match the address map");

    a_err_ready: assert property (
        pslverr |-> pready
    ) else $error("pslverr without pready");

    a_status_q: assert property (
        pready && !pwrite && dfs_decode(paddr) == SEL_STAT
        |-> prdata[`DFS_STAT_Q] == $past(flop_q)
    ) else $error("status read lost the output bit");

    a_cfg_write: assert property (
        acc && pready && pwrite && pstrb[0] && dfs_decode(paddr) == SEL_CTRL
        |=> st.cfg.clocked == $past(pwdata[`DFS_CTRL_CLOCKED])
    ) else $error("force timing write did not land");

    a_load_pulse: assert property (
        st.load |=> !st.load
    ) else $error("load stood longer than one cycle");

    // the edge count is software's only view of lost user clock edges
    a_edge_count: assert property (
        act |=> st.edges == $past(st.edges) + 1'b1
    ) else $error("active edge not counted");

    a_edge_quiet: assert property (
        !act |=> $stable(st.edges)
    ) else $error("edge count moved with no edge");

    c_data_capture: cover property (
        act && !frc && !st.load ##1 flop_q
    );

    c_unclocked_force: cover property (
        !st.cfg.clocked && frc ##1 frc
    );

    c_set_over_en: cover property (
        (st.cfg.variant == NEG_EN_SET) && st.cfg.clocked && frc && act && !st.s2.en
    );

    c_ctrl_write: cover property (
        acc && pready && pwrite && dfs_decode(paddr) == SEL_CTRL
    );

endmodule : dfs_top

`default_nettype wire

/* inc/dfs_defs.svh */
// register offsets, field positions and widths for the flop family block
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

`define DFS_ADDR_W 12
`define DFS_DATA_W 32
`define DFS_EDGE_W 16

`define DFS_CTRL_OFF 12'h000
`define DFS_STAT_OFF 12'h004
`define DFS_EDGE_OFF 12'h008

`define DFS_CTRL_VAR_LSB 0
`define DFS_CTRL_CLOCKED 2
`define DFS_CTRL_INIT_OVR 3
`define DFS_CTRL_INIT_VAL 4
`define DFS_CTRL_LOAD 8

`define DFS_STAT_Q 0
`define DFS_STAT_D 1
`define DFS_STAT_CLK 2
`define DFS_STAT_EN 3
`define DFS_STAT_CLR 4
`define DFS_STAT_SET 5

`endif

/* inc/dfs_pkg.sv */
// types and helper functions shared by the flop family block
`include "dfs_defs.svh"

package dfs_pkg;

    typedef enum logic [1:0] {
        NEG_EN_SET,
        NEG_CLEAR,
        NEG_SET,
        POS_CLEAR
    } dfs_variant_e;

    typedef struct packed {
        dfs_variant_e variant;
        logic clocked;
        logic init_ovr;
        logic init_val;
    } dfs_cfg_t;

    typedef struct packed {
        logic clk;
        logic d;
        logic en;
        logic clear_low;
        logic set_low;
    } dfs_pins_t;

    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_STAT,
        SEL_EDGE,
        SEL_NONE
    } dfs_sel_e;

    function automatic logic dfs_forced_val(input dfs_variant_e v);
        return (v == NEG_EN_SET) || (v == NEG_SET);
    endfunction : dfs_forced_val

    function automatic logic dfs_has_enable(input dfs_variant_e v);
        return v == NEG_EN_SET;
    endfunction : dfs_has_enable

    function automatic logic dfs_force_act(input dfs_variant_e v, input dfs_pins_t p);
        return dfs_forced_val(v) ? !p.set_low : !p.clear_low;
    endfunction : dfs_force_act

endpackage : dfs_pkg
